/* core/rlc_pkg.sv */
// Constants for the retimer link configuration register bank.
// Assumes an 8-bit register port driven by the management serial port decoder.
package rlc_pkg;

  // Device clock and time figures
  localparam int unsigned CLK_FREQ_HZ     = 10_000_000;  // Device clock rate
  localparam int unsigned HPD_LOSS_MS     = 2;           // Hot-plug loss time, ms
  localparam int unsigned HPD_LOSS_CYCLES = (HPD_LOSS_MS * CLK_FREQ_HZ) / 1000;

  // Register offsets
  localparam logic [7:0] OFS_APPLY      = 8'h0a;  // Commit strobe lives here
  localparam logic [7:0] OFS_MISC_LINK  = 8'h0b;  // misc_link_control
  localparam logic [7:0] OFS_SWING      = 8'h0c;  // output_swing_deemphasis
  localparam logic [7:0] OFS_FIXED_EQ   = 8'h0d;  // fixed_equalizer_setting

  // Field positions, misc_link_control
  localparam int TERM_LSB   = 3;   // tx_termination_select 4:3
  localparam int DDC_SPD_B  = 2;   // ddc_bridge_speed_select
  localparam int RATIO_B    = 1;   // clock_ratio_flag
  localparam int TRAIN_B    = 0;   // ddc_training_off
  // Field positions, output_swing_deemphasis
  localparam int DSWING_LSB = 5;   // data_swing_adjust 7:5
  localparam int CSWING_LSB = 2;   // clock_swing_adjust 4:2
  localparam int DEEMPH_LSB = 0;   // postcursor_deemphasis 1:0
  // Field positions, fixed_equalizer_setting
  localparam int DEQ_LSB    = 3;   // data-lane equalizer 5:3
  localparam int CEQ_LSB    = 1;   // clock-lane equalizer 2:1
  localparam int HSW_B      = 0;   // half_clock_swing_inhibit
  // Commit strobe bit in the apply register
  localparam int COMMIT_B   = 2;

  // Reset values
  localparam logic [1:0] TERM_RST   = 2'h0;
  localparam logic [2:0] SWING_RST  = 3'h0;
  localparam logic [1:0] DEEMPH_RST = 2'h0;
  localparam logic [2:0] DEQ_RST    = 3'h0;
  localparam logic [1:0] CEQ_RST    = 2'h0;

  // Snooped display-data-channel target
  localparam logic [7:0] SNOOP_SLAVE = 8'ha8;  // Write address byte
  localparam logic [7:0] SNOOP_OFS   = 8'h20;  // Register offset
  localparam int         SNOOP_BIT   = 1;      // Bit copied into the ratio flag
  localparam logic [3:0] ACK_SLOT    = 4'h8;   // Ninth clock of a byte

  // Mode codes
  localparam logic [1:0] MODE_AUTO_RATIO = 2'h2;  // Retimer chosen by ratio flag

  // Snoop sequencer states
  typedef enum logic [1:0] {SN_IDLE, SN_ADDR, SN_OFFS, SN_DATA} rlc_snoop_t;

endpackage

/* core/rlc_link_config_regs.sv */
// Configuration bank for transmit termination, bridge speed, ratio flag,
// training, swing, de-emphasis and fixed equalizer of a link retimer.
// Assumes the serial port decoder presents byte-wide register accesses
// synchronous to sys_clk, and all pins are already synchronous.
`timescale 1ns/1ns

module rlc_link_config_regs #(
  parameter int unsigned HPD_CYCLES = rlc_pkg::HPD_LOSS_CYCLES,  // Hot-plug loss count
  parameter int unsigned CNT_W      = 16                         // Timer width
) (
  input  wire logic       sys_clk,                 // Device clock
  input  wire logic       rst_b,                   // Async reset, active low
  // Register port from the serial management decoder
  input  wire logic [7:0] reg_addr,                // Register offset
  input  wire logic       reg_wr_en,               // Write strobe, one cycle
  input  wire logic [7:0] reg_wr_data,             // Write data
  input  wire logic       reg_rd_en,               // Read strobe, one cycle
  output logic      [7:0] reg_rd_data,             // Read data, next cycle
  // Straps and mode
  input  wire logic       config_source_select,    // 1 = host, 0 = pins
  input  wire logic [1:0] tx_term_strap,           // Termination strap level
  input  wire logic [1:0] deemphasis_strap_pin,    // De-emphasis strap level
  input  wire logic [1:0] function_mode_select,    // Working mode code
  // Link status
  input  wire logic       sink_hotplug_input,      // Sink hot-plug, high = present
  input  wire logic       link_inactive,           // Link idle or powered down
  input  wire logic       source_side_clock_line,  // Snooped source clock line
  input  wire logic       source_side_data_line,   // Snooped source data line
  // Settings toward the lanes
  output logic      [1:0] lane_termination,        // Applied termination
  output logic      [1:0] lane_deemphasis,         // Applied de-emphasis
  output logic      [2:0] lane_data_swing,         // Applied data swing
  output logic      [2:0] lane_clock_swing,        // Applied clock swing
  output logic      [2:0] lane_data_eq,            // Applied data equalizer
  output logic      [1:0] lane_clock_eq,           // Applied clock equalizer
  output logic            clock_half_swing,        // Halve clock amplitude
  output logic            clock_ratio_div40,       // Clock is 1/40 of bit rate
  output logic            ddc_bridge_fast,         // Bridge at 400 kbps
  output logic            ddc_training_disabled,   // Legacy-only operation
  output logic            retimer_by_ratio         // Auto retimer request
);
  import rlc_pkg::*;

  // Refuse a loss count that the timer cannot hold
  if (HPD_CYCLES < 1 || HPD_CYCLES >= (2 ** CNT_W)) begin : g_bad_timer
    $error("HPD_CYCLES does not fit the timer width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-visible shadow registers
  logic [1:0] term_q,   term_d;      // Host termination
  logic       spd_q,    spd_d;       // Bridge speed
  logic       train_q,  train_d;     // Training off
  logic       ratio_q,  ratio_d;     // Clock ratio flag
  logic [2:0] dsw_q,    dsw_d;       // Data swing
  logic [2:0] csw_q,    csw_d;       // Clock swing
  logic [1:0] demph_q,  demph_d;     // Host de-emphasis
  logic [2:0] deq_q,    deq_d;       // Data equalizer
  logic [1:0] ceq_q,    ceq_d;       // Clock equalizer
  logic       hsw_q,    hsw_d;       // Half swing inhibit
  logic [7:0] rd_q,     rd_d;        // Read data
  logic       pin_mode;              // Straps in charge
  logic [1:0] term_eff;              // Termination seen by software and lanes
  logic [1:0] demph_eff;             // De-emphasis seen by software and lanes
  logic       snoop_hit;             // Snooped data byte seen
  logic       snoop_val;             // Snooped bit value
  logic       hpd_expired;           // Hot-plug gone too long

  assign pin_mode  = ~config_source_select;
  assign term_eff  = pin_mode ? tx_term_strap : term_q;
  assign demph_eff = pin_mode ? deemphasis_strap_pin : demph_q;

  // Field writes, ratio flag priority and read mux
  always_comb begin
    term_d  = term_q;
    spd_d   = spd_q;
    train_d = train_q;
    ratio_d = ratio_q;
    dsw_d   = dsw_q;
    csw_d   = csw_q;
    demph_d = demph_q;
    deq_d   = deq_q;
    ceq_d   = ceq_q;
    hsw_d   = hsw_q;
    rd_d    = rd_q;
    if (reg_wr_en) begin
      unique case (reg_addr)
        OFS_MISC_LINK: begin
          // Strap mode keeps the host termination untouched
          if (!pin_mode) term_d = reg_wr_data[TERM_LSB +: 2];
          spd_d   = reg_wr_data[DDC_SPD_B];
          train_d = reg_wr_data[TRAIN_B];
          ratio_d = reg_wr_data[RATIO_B];
        end
        OFS_SWING: begin
          dsw_d = reg_wr_data[DSWING_LSB +: 3];
          csw_d = reg_wr_data[CSWING_LSB +: 3];
          if (!pin_mode) demph_d = reg_wr_data[DEEMPH_LSB +: 2];
        end
        OFS_FIXED_EQ: begin
          deq_d = reg_wr_data[DEQ_LSB +: 3];
          ceq_d = reg_wr_data[CEQ_LSB +: 2];
          hsw_d = reg_wr_data[HSW_B];
        end
        default: ;  // Other offsets belong elsewhere
      endcase
    end
    // Hardware sources win over a host ratio write in the same cycle; training off wins over both
    if (snoop_hit) ratio_d = snoop_val;
    if (hpd_expired) ratio_d = 1'b0;
    if (train_d) ratio_d = 1'b1;
    if (reg_rd_en) begin
      rd_d = 8'h00;  // Reserved and unmapped bits read zero
      unique case (reg_addr)
        OFS_MISC_LINK: begin
          rd_d[TERM_LSB +: 2] = term_eff;
          rd_d[DDC_SPD_B]     = spd_q;
          rd_d[RATIO_B]       = ratio_q;
          rd_d[TRAIN_B]       = train_q;
        end
        OFS_SWING: begin
          rd_d[DSWING_LSB +: 3] = dsw_q;
          rd_d[CSWING_LSB +: 3] = csw_q;
          rd_d[DEEMPH_LSB +: 2] = demph_eff;
        end
        OFS_FIXED_EQ: begin
          rd_d[DEQ_LSB +: 3] = deq_q;
          rd_d[CEQ_LSB +: 2] = ceq_q;
          rd_d[HSW_B]        = hsw_q;
        end
        default: ;  // Read as zero
      endcase
    end
  end

  // Shadow register flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_q  <= TERM_RST;
      spd_q   <= 1'b0;
      train_q <= 1'b0;
      ratio_q <= 1'b0;
      dsw_q   <= SWING_RST;
      csw_q   <= SWING_RST;
      demph_q <= DEEMPH_RST;
      deq_q   <= DEQ_RST;
      ceq_q   <= CEQ_RST;
      hsw_q   <= 1'b0;
      rd_q    <= 8'h00;
    end else begin
      term_q  <= term_d;
      spd_q   <= spd_d;
      train_q <= train_d;
      ratio_q <= ratio_d;
      dsw_q   <= dsw_d;
      csw_q   <= csw_d;
      demph_q <= demph_d;
      deq_q   <= deq_d;
      ceq_q   <= ceq_d;
      hsw_q   <= hsw_d;
      rd_q    <= rd_d;
    end
  end

  assign reg_rd_data = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Hot-plug loss timer
  logic [CNT_W-1:0] hpd_cnt_q, hpd_cnt_d;  // Cycles with hot-plug low
  localparam logic [CNT_W-1:0] HPD_LIMIT = CNT_W'(HPD_CYCLES);

  // Count while low, saturate at the limit
  always_comb begin
    hpd_cnt_d = hpd_cnt_q;
    if (sink_hotplug_input) hpd_cnt_d = '0;
    else if (hpd_cnt_q != HPD_LIMIT) hpd_cnt_d = hpd_cnt_q + CNT_W'(1);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) hpd_cnt_q <= '0;
    else        hpd_cnt_q <= hpd_cnt_d;
  end

  assign hpd_expired = (hpd_cnt_q == HPD_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Display-data-channel write snoop
  rlc_snoop_t sn_q, sn_d;            // Sequencer state
  logic [3:0] bit_q, bit_d;          // Clock count within a byte
  logic [7:0] sh_q,  sh_d;           // Shifted byte
  logic       scl_q, sda_q;          // Previous line levels
  logic       hit_q, hit_d;          // Data byte caught
  logic       val_q, val_d;          // Caught bit value
  logic       scl_rise, start_c, stop_c;

  assign scl_rise = source_side_clock_line & ~scl_q;
  assign start_c  = source_side_clock_line & scl_q & sda_q & ~source_side_data_line;
  assign stop_c   = source_side_clock_line & scl_q & ~sda_q & source_side_data_line;

  // Byte framing: address, offset, then first data byte
  always_comb begin
    sn_d  = sn_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    hit_d = 1'b0;
    val_d = val_q;
    if (start_c) begin
      sn_d  = SN_ADDR;  // Start or repeated start
      bit_d = 4'h0;
    end else if (stop_c) begin
      sn_d = SN_IDLE;
    end else if (scl_rise && sn_q != SN_IDLE) begin
      if (bit_q != ACK_SLOT) begin
        sh_d  = {sh_q[6:0], source_side_data_line};
        bit_d = bit_q + 4'h1;
      end else begin
        bit_d = 4'h0;  // Acknowledge clock closes the byte
        unique case (sn_q)
          SN_ADDR: sn_d = (sh_q == SNOOP_SLAVE) ? SN_OFFS : SN_IDLE;
          SN_OFFS: sn_d = (sh_q == SNOOP_OFS) ? SN_DATA : SN_IDLE;
          SN_DATA: begin
            hit_d = 1'b1;
            val_d = sh_q[SNOOP_BIT];
            sn_d  = SN_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sn_q  <= SN_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      hit_q <= 1'b0;
      val_q <= 1'b0;
    end else begin
      sn_q  <= sn_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      scl_q <= source_side_clock_line;
      sda_q <= source_side_data_line;
      hit_q <= hit_d;
      val_q <= val_d;
    end
  end

  assign snoop_hit = hit_q;
  assign snoop_val = val_q;

  ////////////////////////////////////////////////////////////////////////////
  // Applied lane settings and status outputs
  logic [1:0] a_term_q,  a_term_d;
  logic [1:0] a_demph_q, a_demph_d;
  logic [2:0] a_dsw_q,   a_dsw_d;
  logic [2:0] a_csw_q,   a_csw_d;
  logic [2:0] a_deq_q,   a_deq_d;
  logic [1:0] a_ceq_q,   a_ceq_d;
  logic       half_q,    half_d;
  logic       auto_q,    auto_d;
  logic       commit;                // Commit strobe, sink hot-plug low or idle link

  assign commit = (reg_wr_en && reg_addr == OFS_APPLY && reg_wr_data[COMMIT_B])
                | ~sink_hotplug_input | link_inactive;

  // Hold applied values until committed
  always_comb begin
    a_term_d  = a_term_q;
    a_demph_d = a_demph_q;
    a_dsw_d   = a_dsw_q;
    a_csw_d   = a_csw_q;
    a_deq_d   = a_deq_q;
    a_ceq_d   = a_ceq_q;
    if (commit) begin
      a_term_d  = term_eff;
      a_demph_d = demph_eff;
      a_dsw_d   = dsw_q;
      a_csw_d   = csw_q;
      a_deq_d   = deq_q;
      a_ceq_d   = ceq_q;
    end
    half_d = ~hsw_q & ratio_q;
    auto_d = (function_mode_select == MODE_AUTO_RATIO) & ratio_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      a_term_q  <= TERM_RST;
      a_demph_q <= DEEMPH_RST;
      a_dsw_q   <= SWING_RST;
      a_csw_q   <= SWING_RST;
      a_deq_q   <= DEQ_RST;
      a_ceq_q   <= CEQ_RST;
      half_q    <= 1'b0;
      auto_q    <= 1'b0;
    end else begin
      a_term_q  <= a_term_d;
      a_demph_q <= a_demph_d;
      a_dsw_q   <= a_dsw_d;
      a_csw_q   <= a_csw_d;
      a_deq_q   <= a_deq_d;
      a_ceq_q   <= a_ceq_d;
      half_q    <= half_d;
      auto_q    <= auto_d;
    end
  end

  assign lane_termination      = a_term_q;
  assign lane_deemphasis       = a_demph_q;
  assign lane_data_swing       = a_dsw_q;
  assign lane_clock_swing      = a_csw_q;
  assign lane_data_eq          = a_deq_q;
  assign lane_clock_eq         = a_ceq_q;
  assign clock_half_swing      = half_q;
  assign clock_ratio_div40     = ratio_q;
  assign ddc_bridge_fast       = spd_q;
  assign ddc_training_disabled = train_q;
  assign retimer_by_ratio      = auto_q;

endmodule // rlc_link_config_regs

/* verif/rlc_ddc_source.sv */
// Source-side display data channel writer that the retimer snoops.
// Assumes open lines with pull-ups; lines idle high between frames.
`timescale 1ns/1ns

module rlc_ddc_source (
  input  wire logic sys_clk,                 // Device clock for pacing
  output logic      source_side_clock_line,  // Driven clock line
  output logic      source_side_data_line    // Driven data line
);
  initial begin
    source_side_clock_line = 1'b1;
    source_side_data_line  = 1'b1;
  end

  // Hold each level three device cycles, over the two-cycle minimum
  task automatic pace();
    repeat (3) @(negedge sys_clk);
  endtask

  // One clock pulse with the data line set while the clock is low
  task automatic bit_out(input logic b);
    source_side_data_line = b;
    pace();
    source_side_clock_line = 1'b1;
    pace();
    source_side_clock_line = 1'b0;
    pace();
  endtask

  // Start, three bytes MSB first with released ack slot, then stop
  task automatic send(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    logic [23:0] w;
    w = {b1, b2, b3};
    source_side_data_line = 1'b0;  // Start while clock high
    pace();
    source_side_clock_line = 1'b0;
    pace();
    for (int i = 23; i >= 0; i--) begin
      bit_out(w[i]);  // MSB first
      if (i % 8 == 0) begin
        bit_out(1'b1);  // Ack slot released to pull-up
      end
    end
    source_side_data_line = 1'b0;
    pace();
    source_side_clock_line = 1'b1;
    pace();
    source_side_data_line = 1'b1;  // Stop while clock high
    pace();
  endtask
endmodule // rlc_ddc_source

/* verif/rlc_link_config_regs_sva.sv */
// Port checker for the link configuration bank.
// Assumes binding to the bank; sees only its ports.
`timescale 1ns/1ns

module rlc_link_config_regs_sva #(
  parameter int unsigned HPD_CYCLES = rlc_pkg::HPD_LOSS_CYCLES  // Hot-plug loss count
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       config_source_select,
  input wire logic [1:0] tx_term_strap,
  input wire logic [1:0] deemphasis_strap_pin,
  input wire logic [1:0] function_mode_select,
  input wire logic       sink_hotplug_input,
  input wire logic       link_inactive,
  input wire logic [2:0] lane_data_swing,
  input wire logic       clock_half_swing,
  input wire logic       clock_ratio_div40,
  input wire logic       ddc_training_disabled,
  input wire logic       retimer_by_ratio
);
  import rlc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  int unsigned low_cnt_q;  // Cycles with hot-plug low, saturating
  logic        cmt;        // Commit or pass-through condition this cycle
  assign cmt = (reg_wr_en && reg_addr == OFS_APPLY && reg_wr_data[COMMIT_B])
               || !sink_hotplug_input || link_inactive;

  ////////////////////////////////////////////////////////////////////////////
  // Hot-plug low counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 0;
    end else begin
      low_cnt_q <= sink_hotplug_input ? 0 : (low_cnt_q < 60000 ? low_cnt_q + 1 : low_cnt_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PIN_TERM: assert property (reg_rd_en && reg_addr == 8'h0b && !config_source_select
    |=> reg_rd_data[4:3] == $past(tx_term_strap)) else $error("termination strap not read");
  AST_PIN_DEEMPH: assert property (reg_rd_en && reg_addr == 8'h0c && !config_source_select
    |=> reg_rd_data[1:0] == $past(deemphasis_strap_pin)) else $error("de-emphasis strap");
  AST_RSV_B: assert property (reg_rd_en && reg_addr == 8'h0b |=> reg_rd_data[7:5] == 3'h0)
    else $error("reserved bits of 0x0b set");
  AST_RSV_D: assert property (reg_rd_en && reg_addr == 8'h0d |=> reg_rd_data[7:6] == 2'h0)
    else $error("reserved bits of 0x0d set");
  AST_UNMAPPED: assert property (reg_rd_en && !(reg_addr inside {[8'h0b:8'h0d]})
    |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
  AST_TRAIN_FORCE: assert property (ddc_training_disabled [*3] |-> clock_ratio_div40)
    else $error("training off did not force ratio flag");
  AST_HALF: assert property (clock_half_swing |-> $past(clock_ratio_div40))
    else $error("half swing without ratio flag");
  AST_AUTO: assert property (retimer_by_ratio ==
    ($past(clock_ratio_div40) && $past(function_mode_select) == MODE_AUTO_RATIO))
    else $error("auto retimer does not follow mode and flag");
  AST_HOLD: assert property (!cmt && !$past(cmt) |=> $stable(lane_data_swing))
    else $error("lane swing moved without commit");
  AST_HPD_LOSS: assert property (low_cnt_q > HPD_CYCLES + 2 && !ddc_training_disabled
    && !$past(ddc_training_disabled) |-> !clock_ratio_div40) else $error("flag kept after loss");
endmodule // rlc_link_config_regs_sva

/* verif/tb_rlc_link_config_regs.sv */
// Self-checking bench for the link configuration bank.
// Assumes the bank, its checker and the snooped source model.
`timescale 1ns/1ns

module tb_rlc_link_config_regs;
  import rlc_pkg::*;
  localparam int unsigned HPD_SIM = 20;  // Shortened hot-plug loss count
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, rd;
  logic config_source_select = 1'b1, sink_hotplug_input = 1'b1, link_inactive = 1'b0;
  logic [1:0] tx_term_strap = 2'h3, deemphasis_strap_pin = 2'h1, function_mode_select = 2'h1;
  logic scl, sda, half, div40, fast, train_off, auto_rt;
  logic [1:0] l_term, l_de, l_ceq;
  logic [2:0] l_dsw, l_csw, l_deq;
  int bad_count = 0, checks_done = 0;

  always #50 sys_clk = ~sys_clk;

  rlc_ddc_source src (.sys_clk(sys_clk), .source_side_clock_line(scl),
    .source_side_data_line(sda));
  rlc_link_config_regs #(.HPD_CYCLES(HPD_SIM), .CNT_W(16)) uut (.sys_clk, .rst_b,
    .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .config_source_select,
    .tx_term_strap, .deemphasis_strap_pin, .function_mode_select, .sink_hotplug_input,
    .link_inactive, .source_side_clock_line(scl), .source_side_data_line(sda),
    .lane_termination(l_term), .lane_deemphasis(l_de), .lane_data_swing(l_dsw),
    .lane_clock_swing(l_csw), .lane_data_eq(l_deq), .lane_clock_eq(l_ceq),
    .clock_half_swing(half), .clock_ratio_div40(div40), .ddc_bridge_fast(fast),
    .ddc_training_disabled(train_off), .retimer_by_ratio(auto_rt));

  ////////////////////////////////////////////////////////////////////////////
  // Access tasks: inputs change at the falling edge
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    repeat (2) @(negedge sys_clk);  // Let registered outputs follow
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    chk(reg_rd_data, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog far beyond the expected nine hundred or so cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    rd_chk(OFS_MISC_LINK, 8'h00);
    rd_chk(OFS_SWING, 8'h00);
    rd_chk(OFS_FIXED_EQ, 8'h00);
    wr(8'h09, 8'h04);
    wr(OFS_MISC_LINK, 8'hff);
    rd_chk(OFS_MISC_LINK, 8'h1f);
    chk({5'h0, fast, train_off, div40}, 8'h07);
    wr(OFS_MISC_LINK, 8'h08);
    rd_chk(OFS_MISC_LINK, 8'h08);
    chk({5'h0, fast, train_off, div40}, 8'h00);
    wr(OFS_SWING, 8'he1);
    rd_chk(OFS_SWING, 8'he1);
    chk({5'h0, l_dsw}, 8'h00);
    wr(OFS_APPLY, 8'h04);
    chk({l_dsw, l_csw, l_de}, 8'he1);
    chk({6'h0, l_term}, 8'h01);
    rd_chk(OFS_APPLY, 8'h00);
    rd_chk(8'h20, 8'h00);
    wr(OFS_FIXED_EQ, 8'hff);
    rd_chk(OFS_FIXED_EQ, 8'h3f);
    wr(OFS_APPLY, 8'h04);
    chk({3'h0, l_deq, l_ceq}, 8'h1f);
    function_mode_select = 2'h2;
    wr(OFS_MISC_LINK, 8'h0a);
    chk({6'h0, half, auto_rt}, 8'h01);
    wr(OFS_FIXED_EQ, 8'h3e);
    chk({7'h0, half}, 8'h01);
    function_mode_select = 2'h1;
    repeat (2) @(negedge sys_clk);
    chk({7'h0, auto_rt}, 8'h00);
    // Snooped writes: right target clears, wrong slave ignored, right sets
    src.send(8'ha8, 8'h20, 8'h00);
    chk({7'h0, div40}, 8'h00);
    src.send(8'ha6, 8'h20, 8'h02);
    chk({7'h0, div40}, 8'h00);
    src.send(8'ha8, 8'h20, 8'h02);
    chk({7'h0, div40}, 8'h01);
    rd_chk(OFS_MISC_LINK, 8'h0a);
    sink_hotplug_input = 1'b0;
    repeat (HPD_SIM + 5) @(negedge sys_clk);
    chk({7'h0, div40}, 8'h00);
    sink_hotplug_input = 1'b1;
    rd_chk(OFS_MISC_LINK, 8'h08);
    link_inactive = 1'b1;
    wr(OFS_SWING, 8'h40);
    chk({5'h0, l_dsw}, 8'h02);
    link_inactive = 1'b0;
    config_source_select = 1'b0;
    // Pin mode: these would change the host termination and de-emphasis if those fields took the writes
    wr(OFS_MISC_LINK, 8'h10);
    wr(OFS_SWING, 8'h42);
    rd_chk(OFS_MISC_LINK, 8'h18);
    rd_chk(OFS_SWING, 8'h41);
    wr(OFS_APPLY, 8'h04);
    chk({4'h0, l_term, l_de}, 8'h0d);
    // Back in host mode the old host values must remain
    config_source_select = 1'b1;
    rd_chk(OFS_MISC_LINK, 8'h08);
    rd_chk(OFS_SWING, 8'h40);
    stop_test();
  end
endmodule // tb_rlc_link_config_regs

bind rlc_link_config_regs rlc_link_config_regs_sva #(.HPD_CYCLES(HPD_CYCLES)) u_sva (
  .sys_clk, .rst_b, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
  .config_source_select, .tx_term_strap, .deemphasis_strap_pin, .function_mode_select,
  .sink_hotplug_input, .link_inactive, .lane_data_swing, .clock_half_swing,
  .clock_ratio_div40, .ddc_training_disabled, .retimer_by_ratio);
